// ### hdl/byte_order_swap.v
`timescale 1ns/100ps

// byte reordering between link order and word order; its own inverse
module byte_order_swap
(
	// mode
	input  wire        big_endian_i,
	input  wire        word16_i,
	// data
	input  wire [31:0] d_i,
	output reg  [31:0] q_o
);

	// big endian passes through; little swaps per halfword or whole word
	always @*
	begin
		if (big_endian_i)
			q_o = d_i;
		else if (word16_i)
			q_o = {d_i[23:16], d_i[31:24], d_i[7:0], d_i[15:8]};
		else
			q_o = {d_i[7:0], d_i[15:8], d_i[23:16], d_i[31:24]};
	end
endmodule

// ### hdl/sync_2ff.v
`timescale 1ns/100ps

// two flip-flop synchroniser, one per bit
module sync_2ff
#(
	parameter             WIDTH     = 1,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
	// clock and reset
	input  wire             clk_i,
	input  wire             arst_n_i,
	// data
	input  wire [WIDTH-1:0] d_i,
	output wire [WIDTH-1:0] q_o
);

	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage feeds only the second stage
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end
		else
		begin
			meta_reg <= d_i;
			sync_reg <= meta_reg;
		end
	end

	assign q_o = sync_reg;
endmodule

// ### hdl/wlan_serial_host_port.v
`timescale 1ns/100ps
`include "wlan_spi_defines.vh"

module wlan_serial_host_port
#(
	parameter [31:0] TEST_PATTERN = 32'hc3a5_5a3c // arbitrary value
)
(
	// clock and reset
	input  wire        clk_i,
	input  wire        arst_n_i,
	// link pins
	input  wire        spi_clk_i,
	input  wire        sd_data_line_three_n_i,
	input  wire        sd_cmd_i,
	output wire        sd_data_line_zero_o,
	output wire        sd_data_line_zero_oe_o,
	output wire        sd_data_line_one_o,
	output wire        sd_data_line_one_oe_o,
	output wire        sd_data_line_two_oe_o,
	// straps
	input  wire [2:0]  strap_host_ifc_i,
	output wire        serial_mode_o,
	// write path to functions
	output reg         wr_valid_o,
	output reg  [1:0]  wr_func_o,
	output reg  [16:0] wr_addr_o,
	output reg  [31:0] wr_data_o,
	// read path from functions
	output wire        rd_req_o,
	output wire [1:0]  rd_func_o,
	output wire [16:0] rd_addr_o,
	input  wire [31:0] rd_data_i,
	input  wire        rd_avail_i,
	// status sources
	input  wire        underflow_i,
	input  wire        overflow_i,
	input  wire [1:0]  pkt_int_i,
	input  wire [1:0]  rx_empty_i,
	input  wire [1:0]  pkt_avail_i,
	input  wire [10:0] pkt_len_a_i,
	input  wire [10:0] pkt_len_b_i,
	input  wire        backplane_int_i,
	// wake-up
	output reg         wake_req_o,
	input  wire        chip_ready_i,
	// configuration view
	output wire        word32_o,
	output wire        big_endian_o,
	output wire        high_speed_o,
	output wire        status_en_o,
	output wire [7:0]  resp_delay_o
);

	// ****************************************************************
	// states
	// ****************************************************************
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_CMD   = 3'h1;
	localparam [2:0] S_WDATA = 3'h2;
	localparam [2:0] S_DELAY = 3'h3;
	localparam [2:0] S_RDATA = 3'h4;
	localparam [2:0] S_STAT  = 3'h5;
	localparam [2:0] S_DONE  = 3'h6;

	// ****************************************************************
	// declarations
	// ****************************************************************
	wire [5:0]  pins_s;
	wire [2:0]  strap_s;
	wire        sclk_s;
	wire        cs_n_s;
	wire        di_s;
	reg         sclk_d_reg;
	reg  [1:0]  strap_cnt_reg;
	reg         serial_mode_reg;
	reg  [7:0]  cfg0_reg;
	reg  [7:0]  delay_reg;
	reg  [7:0]  cfg2_reg;
	reg  [2:0]  state_reg;
	reg  [4:0]  bit_cnt_reg;
	reg  [10:0] dly_cnt_reg;
	reg  [11:0] words_reg;
	reg  [11:0] len_reg;
	reg  [1:0]  func_reg;
	reg  [16:0] addr_reg;
	reg         incr_reg;
	reg         first_reg;
	reg  [30:0] rx_sh_reg;
	reg  [31:0] tx_sh_reg;
	reg  [31:0] hold_reg;
	reg         pend_reg;
	reg         no_data_reg;
	reg         under_reg;
	reg         over_reg;
	reg         wake_pend_reg;
	reg         irq_reg;

	// ****************************************************************
	// pin synchronisers and link clock edges
	// ****************************************************************
	sync_2ff #(.WIDTH(6), .RESET_VAL(6'h02)) u_pin_sync
	(
		.clk_i    (clk_i),
		.arst_n_i (arst_n_i),
		.d_i      ({strap_host_ifc_i, spi_clk_i,
		            sd_data_line_three_n_i, sd_cmd_i}),
		.q_o      (pins_s)
	);

	assign strap_s = pins_s[5:3];
	assign sclk_s  = pins_s[2];
	assign cs_n_s  = pins_s[1];
	assign di_s    = pins_s[0];

	wire cfg_word32 = cfg0_reg[`CFG0_WORD32];
	wire cfg_big    = cfg0_reg[`CFG0_BIG_ENDIAN];
	wire cfg_hs     = cfg0_reg[`CFG0_HIGH_SPEED];
	wire link_on    = serial_mode_reg & ~cs_n_s;
	// oversampling limits the usable link clock to well under clk_i/4
	wire rx_edge    = link_on & sclk_s & ~sclk_d_reg;
	wire fall_edge  = link_on & ~sclk_s & sclk_d_reg;
	wire tx_edge    = cfg_hs ? rx_edge : fall_edge;

	// strap capture a few cycles after reset release
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sclk_d_reg      <= 1'b0;
			strap_cnt_reg   <= 2'h0;
			serial_mode_reg <= 1'b0;
		end
		else
		begin
			sclk_d_reg <= sclk_s;
			// straps are taken once; later pin changes are ignored
			if (strap_cnt_reg != 2'h3)
				strap_cnt_reg <= strap_cnt_reg + 2'h1;
			if (strap_cnt_reg == `STRAP_SETTLE)
				serial_mode_reg <= (strap_s == `STRAP_SERIAL_MODE);
		end
	end

	// ****************************************************************
	// receive word and command decode
	// ****************************************************************
	wire [31:0] rx_full = {rx_sh_reg, di_s};
	wire [31:0] rx_raw  = (cfg_word32 || state_reg == S_CMD) ? rx_full
	                      : {16'h0000, rx_full[15:0]};
	wire [31:0] rx_val;

	byte_order_swap u_rx_swap
	(
		.big_endian_i (cfg_big),
		.word16_i     (~cfg_word32),
		.d_i          (rx_raw),
		.q_o          (rx_val)
	);

	wire        cmd_write = rx_val[`CMD_WRITE_BIT];
	wire        cmd_incr  = rx_val[`CMD_INCR_BIT];
	wire [1:0]  cmd_func  = rx_val[`CMD_FUNC_HI:`CMD_FUNC_LO];
	wire [16:0] cmd_addr  = rx_val[`CMD_ADDR_HI:`CMD_ADDR_LO];
	wire [10:0] cmd_len   = rx_val[`CMD_LEN_HI:`CMD_LEN_LO];
	// zero length means a full frame
	wire [11:0] len_eff   = (cmd_len == 11'h000) ? `MAX_FRAME_BYTES
	                        : {1'b0, cmd_len};
	wire [12:0] len_sum   = {1'b0, len_eff} + (cfg_word32 ? 13'h0003
	                                                       : 13'h0001);
	wire [11:0] cmd_words = cfg_word32 ? {1'b0, len_sum[12:2]}
	                        : len_sum[12:1];
	wire        cmd_delay = ~cmd_write && (delay_reg != 8'h00) &&
	                        (cmd_func == `FN_BACKPLANE ||
	                         cfg2_reg[`CFG2_DELAY_ALL]);

	// word boundaries: command and status are always 32 bits
	wire [4:0]  word_last = (state_reg == S_CMD || state_reg == S_STAT ||
	                         cfg_word32) ? 5'd31 : 5'd15;
	wire        bnd       = rx_edge && bit_cnt_reg == word_last;
	wire        status_en = cfg2_reg[`CFG2_STATUS_EN];
	wire [16:0] step      = cfg_word32 ? 17'h00004 : 17'h00002;

	// ****************************************************************
	// load decisions for the transmit shifter
	// ****************************************************************
	wire go_read   = bnd && state_reg == S_CMD && ~cmd_write && ~cmd_delay;
	wire dly_end   = rx_edge && state_reg == S_DELAY &&
	                 dly_cnt_reg == 11'h000;
	wire more_rd   = bnd && state_reg == S_RDATA && words_reg != 12'h001;
	wire last_data = bnd && (state_reg == S_RDATA || state_reg == S_WDATA)
	                 && words_reg == 12'h001;
	wire load_read = go_read | dly_end | more_rd;
	wire load_stat = last_data & status_en;
	wire in_cmd    = state_reg == S_CMD;
	wire [1:0]  cur_func = in_cmd ? cmd_func : func_reg;
	wire [16:0] cur_addr = in_cmd ? cmd_addr : addr_reg;
	wire        cur_bus  = cur_func == `FN_BUS_CONTROL;

	// read request handshake, answered in the same cycle
	assign rd_req_o  = load_read & ~cur_bus;
	assign rd_func_o = cur_func;
	assign rd_addr_o = cur_addr;

	// bus control function read view
	wire [31:0] bus_rd = (cur_addr == `REG_CFG0_ADDR) ?
	                     {8'h00, cfg2_reg, delay_reg, cfg0_reg} :
	                     (cur_addr == `REG_TEST_ADDR) ? TEST_PATTERN :
	                     32'h0000_0000;
	wire        miss     = rd_req_o & ~rd_avail_i;
	wire [31:0] rd_val   = cur_bus ? bus_rd : rd_data_i;

	// status word, including a miss of the very word just loaded
	wire [31:0] status_word;
	assign status_word[`ST_NO_DATA]   = no_data_reg;
	assign status_word[`ST_UNDERFLOW] = under_reg | underflow_i;
	assign status_word[`ST_OVERFLOW]  = over_reg | overflow_i;
	assign status_word[`ST_INT_A]     = pkt_int_i[0];
	assign status_word[`ST_INT_B]     = pkt_int_i[1];
	assign status_word[`ST_RX_READY_A] = rx_empty_i[0];
	assign status_word[`ST_RX_READY_B] = rx_empty_i[1];
	assign status_word[7]             = 1'b0;
	assign status_word[`ST_PKT_A]     = pkt_avail_i[0];
	assign status_word[`ST_PKT_B-1:`ST_LEN_A_LO] = pkt_len_a_i;
	assign status_word[`ST_PKT_B]     = pkt_avail_i[1];
	assign status_word[31:`ST_LEN_B_LO] = pkt_len_b_i;

	wire [31:0] tx_val  = load_stat ? status_word : rd_val;
	wire        tx_wide = load_stat | cfg_word32;
	wire [31:0] tx_sw;
	wire [31:0] tx_aligned = tx_wide ? tx_sw : {tx_sw[15:0], 16'h0000};

	byte_order_swap u_tx_swap
	(
		.big_endian_i (cfg_big),
		.word16_i     (~cfg_word32),
		.d_i          (tx_val),
		.q_o          (tx_sw)
	);

	// ****************************************************************
	// transaction sequencer
	// ****************************************************************
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg   <= S_IDLE;
			bit_cnt_reg <= 5'h00;
			dly_cnt_reg <= 11'h000;
			words_reg   <= 12'h000;
			len_reg     <= 12'h000;
			func_reg    <= 2'h0;
			addr_reg    <= 17'h00000;
			incr_reg    <= 1'b0;
			first_reg   <= 1'b0;
			rx_sh_reg   <= 31'h0;
		end
		else if (cs_n_s || !serial_mode_reg)
			state_reg <= S_IDLE;  // select high ends any phase
		else
		begin
			if (rx_edge)
			begin
				rx_sh_reg   <= rx_full[30:0];
				bit_cnt_reg <= bnd ? 5'h00 : bit_cnt_reg + 5'h01;
			end
			case (state_reg)
				S_IDLE:
				begin
					state_reg   <= S_CMD;
					bit_cnt_reg <= 5'h00;
				end
				S_CMD:
					if (bnd)  // 32-bit command decoded
					begin
						func_reg  <= cmd_func;
						incr_reg  <= cmd_incr;
						words_reg <= cmd_words;
						len_reg   <= len_eff;
						first_reg <= 1'b1;
						addr_reg  <= (go_read && cmd_incr) ? cmd_addr + step
						             : cmd_addr;
						dly_cnt_reg <= {delay_reg, 3'b000} - 11'h001;
						if (cmd_write)
							state_reg <= S_WDATA;
						else if (cmd_delay)
							state_reg <= S_DELAY;
						else
							state_reg <= S_RDATA;
					end
				S_DELAY:
					if (rx_edge)
					begin
						dly_cnt_reg <= dly_cnt_reg - 11'h001;
						if (dly_end)
						begin
							state_reg   <= S_RDATA;
							bit_cnt_reg <= 5'h00;
							if (incr_reg)
								addr_reg <= addr_reg + step;
						end
					end
				S_WDATA, S_RDATA:
					if (bnd)
					begin
						words_reg <= words_reg - 12'h001;
						first_reg <= 1'b0;
						if (incr_reg && (state_reg == S_WDATA || more_rd))
							addr_reg <= addr_reg + step;
						if (last_data)
							state_reg <= status_en ? S_STAT : S_DONE;
					end
				S_STAT:
					if (bnd)
						state_reg <= S_DONE;
				S_DONE:
					state_reg <= S_DONE;
				default:
					state_reg <= S_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// transmit shifter
	// ****************************************************************
	// fast mode loads on the closing edge itself; normal mode holds the
	// word for the following falling edge
	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			tx_sh_reg <= 32'h0000_0000;
			hold_reg  <= 32'h0000_0000;
			pend_reg  <= 1'b0;
		end
		else if (cs_n_s)
			pend_reg <= 1'b0;
		else
		begin
			if ((load_read || load_stat) && !cfg_hs)
			begin
				hold_reg <= tx_aligned;
				pend_reg <= 1'b1;
			end
			if (tx_edge)
			begin
				if (cfg_hs && (load_read || load_stat))
					tx_sh_reg <= tx_aligned;
				else if (!cfg_hs && pend_reg)
				begin
					tx_sh_reg <= hold_reg;
					pend_reg  <= 1'b0;
				end
				else
					tx_sh_reg <= {tx_sh_reg[30:0], 1'b0};
			end
		end
	end

	// ****************************************************************
	// writes, configuration and per-transaction flags
	// ****************************************************************
	wire wr_word = bnd && state_reg == S_WDATA;
	wire bus_wr  = wr_word && func_reg == `FN_BUS_CONTROL && first_reg;
	wire wake_wr = bus_wr && addr_reg == `REG_CFG0_ADDR &&
	               rx_val[`CFG0_WAKE];

	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cfg0_reg      <= `CFG0_RESET;
			delay_reg     <= `RESP_DELAY_RESET;
			cfg2_reg      <= `CFG2_RESET;
			wr_valid_o    <= 1'b0;
			wr_func_o     <= 2'h0;
			wr_addr_o     <= 17'h00000;
			wr_data_o     <= 32'h0000_0000;
			wake_req_o    <= 1'b0;
			wake_pend_reg <= 1'b0;
			no_data_reg   <= 1'b0;
			under_reg     <= 1'b0;
			over_reg      <= 1'b0;
		end
		else
		begin
			wr_valid_o <= wr_word && func_reg != `FN_BUS_CONTROL;
			if (wr_word)
			begin
				wr_func_o <= func_reg;
				wr_addr_o <= addr_reg;
				wr_data_o <= rx_val;
			end
			// bus control bytes, bounded by the command length
			if (bus_wr && addr_reg == `REG_CFG0_ADDR)
			begin
				cfg0_reg <= rx_val[7:0] & 8'h7f;  // wake is not stored
				if (len_reg >= 12'h002)
					delay_reg <= rx_val[15:8];
				if (len_reg >= 12'h003 && cfg_word32)
					cfg2_reg <= rx_val[23:16] & 8'h07;
			end
			else if (bus_wr && addr_reg == `REG_CFG2_ADDR)
				cfg2_reg <= rx_val[7:0] & 8'h07;
			wake_req_o <= wake_wr;
			// set wins over the clear at the start of a new command
			if (wake_wr)
				wake_pend_reg <= 1'b1;
			else if (state_reg == S_IDLE && link_on && chip_ready_i)
				wake_pend_reg <= 1'b0;
			if (miss)
				no_data_reg <= 1'b1;
			else if (state_reg == S_IDLE)
				no_data_reg <= 1'b0;
			if (underflow_i)
				under_reg <= 1'b1;
			else if (state_reg == S_IDLE)
				under_reg <= 1'b0;
			if (overflow_i)
				over_reg <= 1'b1;
			else if (state_reg == S_IDLE)
				over_reg <= 1'b0;
		end
	end

	// ****************************************************************
	// interrupt pin
	// ****************************************************************
	// all events are held back mid-transfer while the status word is enabled and CFG2_IRQ_W_STAT is clear
	wire irq_event  = backplane_int_i | (|pkt_int_i) |
	                  (wake_pend_reg & chip_ready_i);
	wire irq_active = irq_event & (~status_en | cfg2_reg[`CFG2_IRQ_W_STAT] |
	                  cs_n_s);

	always @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_reg <= 1'b0;
		else
			irq_reg <= irq_active ~^ cfg0_reg[`CFG0_IRQ_POL];
	end

	// ****************************************************************
	// pin roles and configuration view
	// ****************************************************************
	assign sd_data_line_zero_o    = tx_sh_reg[31];
	assign sd_data_line_zero_oe_o = link_on;
	assign sd_data_line_one_o     = irq_reg;
	assign sd_data_line_one_oe_o  = serial_mode_reg;
	assign sd_data_line_two_oe_o  = 1'b0;               // unused line
	assign serial_mode_o          = serial_mode_reg;
	assign word32_o               = cfg_word32;
	assign big_endian_o           = cfg_big;
	assign high_speed_o           = cfg_hs;
	assign status_en_o            = status_en;
	assign resp_delay_o           = delay_reg;
endmodule

// ### hdl/wlan_spi_defines.vh
`ifndef WLAN_SPI_DEFINES_VH
`define WLAN_SPI_DEFINES_VH

// ****************************************************************
// command word layout
// ****************************************************************
`define CMD_WRITE_BIT    31
`define CMD_INCR_BIT     30
`define CMD_FUNC_HI      29
`define CMD_FUNC_LO      28
`define CMD_ADDR_HI      27
`define CMD_ADDR_LO      11
`define CMD_LEN_HI       10
`define CMD_LEN_LO       0
`define CMD_BITS         32
`define MAX_FRAME_BYTES  12'd2048

// ****************************************************************
// function numbers and bus control registers
// ****************************************************************
`define FN_BUS_CONTROL   2'h0
`define FN_BACKPLANE     2'h1
`define REG_CFG0_ADDR    17'h00000
`define REG_CFG2_ADDR    17'h00002
`define REG_TEST_ADDR    17'h00014
`define CFG0_WORD32      0
`define CFG0_BIG_ENDIAN  1
`define CFG0_HIGH_SPEED  4
`define CFG0_IRQ_POL     5
`define CFG0_WAKE        7
`define CFG0_RESET       8'h30
`define RESP_DELAY_RESET 8'h04
`define CFG2_STATUS_EN   0
`define CFG2_IRQ_W_STAT  1
`define CFG2_DELAY_ALL   2
`define CFG2_RESET       8'h01

// ****************************************************************
// status word layout
// ****************************************************************
`define ST_NO_DATA       0
`define ST_UNDERFLOW     1
`define ST_OVERFLOW      2
`define ST_INT_A         3
`define ST_INT_B         4
`define ST_RX_READY_A    5
`define ST_RX_READY_B    6
`define ST_PKT_A         8
`define ST_LEN_A_LO      9
`define ST_PKT_B         20
`define ST_LEN_B_LO      21

// ****************************************************************
// strap decode and start-up timing
// ****************************************************************
`define STRAP_SERIAL_MODE 3'h2
`define STRAP_SETTLE      2'h2

`endif

// ### testbench/spi_host_model.sv
`timescale 1ns/100ps
// host master; 160 ns period, under the 48 MHz ceiling
module spi_host_model
(
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      di_o,
	input  wire logic do_i
);
	// clock still outside frames, data line pulled up
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		di_o = 1'b1;
	end
	// select frames each transaction
	task automatic sel(input logic on);
		#80 cs_n_o = !on;
		if (!on) di_o = 1'b1;
	endtask
	// msb first, bit set half a period early
	task automatic shift(input logic [31:0] w, input int n,
		output logic [31:0] r);
		r = '0;
		for (int i = n - 1; i >= 0; i--)
		begin
			di_o = w[i];
			#80 sclk_o = 1'b1;
			r = {r[30:0], do_i};
			#80 sclk_o = 1'b0;
		end
	endtask
endmodule

// ### testbench/wlan_serial_host_port_asserts.sv
`timescale 1ns/100ps
// port watcher: pulses, pin roles, select framing
module wlan_serial_host_port_asserts
(
	input wire logic       clk_i,
	input wire logic       arst_n_i,
	input wire logic       sd_data_line_three_n_i,
	input wire logic       sd_data_line_zero_oe_o,
	input wire logic       sd_data_line_one_oe_o,
	input wire logic       sd_data_line_two_oe_o,
	input wire logic       serial_mode_o,
	input wire logic       wr_valid_o,
	input wire logic       rd_req_o,
	input wire logic [1:0] rd_func_o,
	input wire logic       wake_req_o,
	input wire logic       word32_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// unused line never driven
	property p_nc_off;
		!sd_data_line_two_oe_o;
	endproperty
	a_nc_off: assert property (p_nc_off) else $error("line two driven");
	property p_irq_oe;
		sd_data_line_one_oe_o == serial_mode_o;
	endproperty
	a_irq_oe: assert property (p_irq_oe) else $error("irq pin enable");
	property p_oe_mode;
		sd_data_line_zero_oe_o |-> serial_mode_o;
	endproperty
	a_oe_mode: assert property (p_oe_mode) else $error("out without mode");
	// sync delay allows a few cycles before release
	property p_oe_off;
		$rose(sd_data_line_three_n_i) |-> ##[1:6] !sd_data_line_zero_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("out held");
	property p_rd_one;
		rd_req_o |-> rd_func_o != 2'h0 ##1 !rd_req_o;
	endproperty
	a_rd_one: assert property (p_rd_one) else $error("read request");
	// a word is at least 16 link bits apart
	property p_wr_gap;
		wr_valid_o |=> !wr_valid_o [*8];
	endproperty
	a_wr_gap: assert property (p_wr_gap) else $error("write pulse");
	property p_wake;
		wake_req_o |=> !wake_req_o [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("wake pulse");
	property p_cfg;
		!sd_data_line_zero_oe_o |=> $stable(word32_o);
	endproperty
	a_cfg: assert property (p_cfg) else $error("size changed idle");
endmodule

bind wlan_serial_host_port wlan_serial_host_port_asserts
	wlan_serial_host_port_asserts_inst (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .sd_data_line_three_n_i(sd_data_line_three_n_i),
	.sd_data_line_zero_oe_o(sd_data_line_zero_oe_o),
	.sd_data_line_one_oe_o(sd_data_line_one_oe_o),
	.sd_data_line_two_oe_o(sd_data_line_two_oe_o),
	.serial_mode_o(serial_mode_o), .wr_valid_o(wr_valid_o),
	.rd_req_o(rd_req_o), .rd_func_o(rd_func_o),
	.wake_req_o(wake_req_o), .word32_o(word32_o));

// ### testbench/wlan_serial_host_port_test.sv
`timescale 1ns/100ps
module wlan_serial_host_port_test;
	localparam [31:0] TP = 32'h5a0f_a50f; // arbitrary value
	logic        clk_i = 0, arst_n_i = 0, woke = 0;
	logic        und = 0, ovf = 0, bpi = 0, rdy = 0, ravl = 1;
	logic [1:0]  pint = 0, rxe = 0, pav = 0;
	logic [10:0] la = 0, lb = 0;
	logic [16:0] cap_a;
	logic [18:0] cap_w;
	logic [31:0] rdat = 0, rd, st, cap_d, w;
	wire         sclk, cs_n, di, dout, oe0, irq, oe1, oe2, smode, wrv, rrq;
	wire         wake, w32, be, hs, sten;
	wire         line0 = oe0 ? dout : 1'b1; // released line reads pull-up
	wire  [1:0]  wrf, rf;
	wire  [16:0] wra, ra;
	wire  [31:0] wrd;
	wire  [7:0]  rdly;
	int          fail_count = 0, samples_checked = 0, cyc = 0;

	always #10 clk_i = !clk_i;
	wlan_serial_host_port #(.TEST_PATTERN(TP)) wlan_serial_host_port_inst (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .spi_clk_i(sclk),
		.sd_data_line_three_n_i(cs_n), .sd_cmd_i(di),
		.sd_data_line_zero_o(dout), .sd_data_line_zero_oe_o(oe0),
		.sd_data_line_one_o(irq), .sd_data_line_one_oe_o(oe1),
		.sd_data_line_two_oe_o(oe2), .strap_host_ifc_i(3'h2),
		.serial_mode_o(smode), .wr_valid_o(wrv), .wr_func_o(wrf),
		.wr_addr_o(wra), .wr_data_o(wrd), .rd_req_o(rrq),
		.rd_func_o(rf), .rd_addr_o(ra), .rd_data_i(rdat),
		.rd_avail_i(ravl), .underflow_i(und), .overflow_i(ovf),
		.pkt_int_i(pint), .rx_empty_i(rxe), .pkt_avail_i(pav),
		.pkt_len_a_i(la), .pkt_len_b_i(lb), .backplane_int_i(bpi),
		.wake_req_o(wake), .chip_ready_i(rdy), .word32_o(w32),
		.big_endian_o(be), .high_speed_o(hs), .status_en_o(sten),
		.resp_delay_o(rdly));
	spi_host_model spi_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n),
		.di_o(di), .do_i(line0));

	// capture one-cycle strobes; timeout guards a hang
	always @(posedge clk_i)
	begin
		cyc++;
		if (rrq) cap_a <= ra;
		if (wrv) cap_d <= wrd;
		if (wrv) cap_w <= {wrf, wra};
		if (wake) woke <= 1'b1;
		if (cyc == 30000)
		begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic logic [31:0] cmd(input logic wr, input logic [1:0] f,
		input logic [16:0] a, input logic [10:0] n);
		return {wr, 1'b1, f, a, n};
	endfunction

	function automatic logic [31:0] exp_st(input logic nd, ov);
		return {lb, pav[1], la, pav[0], 1'b0, rxe, pint, ov, 1'b0, nd};
	endfunction

	// command, optional delay word, data, then status if enabled
	task automatic trx(input logic [31:0] c, d, input int n, dl);
		spi_host_model_inst.sel(1'b1);
		spi_host_model_inst.shift(c, 32, st);
		if (dl) spi_host_model_inst.shift(0, 32, st);
		spi_host_model_inst.shift(d, n, rd);
		if (sten) spi_host_model_inst.shift(0, 32, st);
		spi_host_model_inst.sel(1'b0);
		#400;
	endtask

	initial
	begin
		void'($urandom(11));
		repeat (4) @(negedge clk_i);
		arst_n_i = 1'b1;
		repeat (10) @(negedge clk_i);
		chk({hs, sten, rdly}, 10'h304);
		chk({w32, be, smode, oe1, oe2}, 5'h06);
		// little endian 16-bit: bytes swapped in each halfword
		trx(32'h00c0_0100, 16'h3300, 16, 0);
		chk({w32, be, hs}, 3'h7);
		for (int k = 0; k < 5; k++)
		begin
			@(negedge clk_i);
			{pint, rxe, pav, la, lb} = k ? $urandom : '1;
			trx(cmd(0, 0, 17'h14, 4), 0, 32, 0);
			chk(rd, TP);
			chk(st, exp_st(0, 0));
		end
		// backplane reads pass the delay word; second has no data
		for (int k = 0; k < 2; k++)
		begin
			@(negedge clk_i);
			rdat = $urandom;
			ravl = k[0] ? 1'b0 : 1'b1;
			w = $urandom;
			trx(cmd(0, 1, w[16:0], 4), 0, 32, 1);
			if (k == 0) chk(rd, rdat);
			chk(cap_a, w[16:0]);
			chk(st, exp_st(k[0], 0));
		end
		w = $urandom;
		fork
			trx(cmd(1, 1, 17'h40, 4), w, 32, 0);
			begin
				repeat (100) @(negedge clk_i);
				ovf = 1'b1;
				@(negedge clk_i);
				ovf = 1'b0;
			end
		join
		chk(cap_d, w);
		chk(cap_w, {2'h1, 17'h40});
		chk(st, exp_st(0, 1));
		pint = 2'h0;
		trx(cmd(1, 0, 17'h0, 1), 32'hb3, 32, 0);
		chk({woke, irq}, 2'h2);
		@(negedge clk_i);
		rdy = 1'b1;
		repeat (6) @(negedge clk_i);
		chk(irq, 1);
		// status off, then opposite edges for output
		trx(cmd(1, 0, 17'h2, 1), 0, 32, 0);
		chk(sten, 0);
		trx(cmd(1, 0, 17'h0, 1), 32'h23, 32, 0);
		chk(hs, 0);
		trx(cmd(0, 0, 17'h14, 4), 0, 32, 0);
		chk(rd, TP);
		// 32-bit little endian, irq active low; command goes byte reversed
		trx(cmd(1, 0, 17'h0, 1), 32'h01, 32, 0);
		w = cmd(0, 0, 17'h0, 4);
		trx({w[7:0], w[15:8], w[23:16], w[31:24]}, 0, 32, 0);
		chk(rd, 32'h0104_0000);
		chk(irq, 1);
		report_and_stop();
	end
endmodule
